/* File: hdl/ddr2_clock_stop_and_bank_config.sv */
// Power sequencing, clock-stop control and bank configuration decode for a DDR2 controller.
// Assumes the memory-core clock comes from outside and that access and refresh
// status flags are reported by the command engine on the bus-side clock.
//
// Contract
// (RULE1) Self-refresh only after accesses and refreshes drain
// (RULE2) Core clock stops only when stop allowed
// (RULE3) Loop powers down when power-down bit set
// (RULE4) Ready flag low when clock stopped, loop down
// (RULE5) Late access wakes loop, restarts clock, proceeds
// (RULE6) No accesses completed while bus clock disabled
// (RULE7) Software drains, sets bits, polls before gating
// (RULE8) Software gates bus clock then source clock
// (RULE9) Software restarts clocks then clears bits
// (RULE10) Software soft-resets controller after loop powers up
// (RULE11) Software clears self-refresh request last
// (RULE12) Controller keeps working during debug halts
// (RULE13) Unlock bit gates timing register updates
// (RULE14) Software unlocks timing only when changing
// (RULE15) Bus select zero means 32-bit bus
// (RULE16) CAS field four means four cycles
// (RULE17) Bank field three means eight banks
// (RULE18) Page field two means 1024 words
// (RULE19) Supports 32-bit dual and 16-bit single device
// (RULE20) Memory in self-refresh before clocks gated
// (RULE21) Refresh interval counted in memory clock cycles
// (RULE22) Timing fields hold cycles minus one
// (RULE23) Software sets read latency from CAS and board
// (RULE24) Ready flag returns once relocked and running
`timescale 1ns/1ns
module ddr2_clock_stop_and_bank_config
    import ddr2_pm_pkg::*;
#(
    parameter int IVL_W = 16,
    parameter int TIM_W = 32,
    parameter int LOCK_CYCLES = DLL_LOCK_CYCLES
)(
    // Bus-side clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Memory-core clock and its domain reset.
    input wire logic mem_clk,
    input wire logic mem_rstn,
    // Software control bits.
    input wire logic self_refresh_request,
    input wire logic mem_clock_stop_allow,
    input wire logic dll_power_down,
    input wire logic bus_clock_enabled,
    input wire logic debug_halt,
    // Bank configuration and timing write port.
    input wire bank_cfg_t bank_cfg_in,
    input wire logic bank_cfg_we,
    input wire logic [IVL_W-1:0] refresh_interval_in,
    input wire logic refresh_interval_we,
    input wire logic [TIM_W-1:0] timing_one_in,
    input wire logic timing_one_we,
    input wire logic [TIM_W-1:0] timing_two_in,
    input wire logic timing_two_we,
    // Command engine status on the bus-side clock.
    input wire logic access_request,
    input wire logic access_pending,
    input wire logic refresh_backlog,
    // Outputs to the command engine.
    output logic access_grant,
    output logic enter_self_refresh,
    output logic dll_enable,
    output logic mem_clock_run,
    output logic phy_ready_flag,
    // Stored configuration.
    output bank_cfg_t bank_cfg,
    output geom_t geometry,
    output logic [IVL_W-1:0] refresh_interval_count,
    output logic [TIM_W-1:0] timing_reg_one,
    output logic [TIM_W-1:0] timing_reg_two,
    // Refresh tick in the memory-core domain.
    output logic refresh_tick
);

    // Refuse parameter values the logic cannot serve.
    initial
    begin
        if (IVL_W < 2 || IVL_W > 16 || TIM_W < 1 || TIM_W > 32 || LOCK_CYCLES < 1
            || LOCK_CYCLES > 65535)
        begin
            $error("Unsupported parameter values.");
        end
    end

    // Sequencing state and its next value.
    pm_state_t state_reg;
    pm_state_t state_next;
    // Relock wait counter.
    logic [15:0] lock_cnt_reg;
    // Core-clock running acknowledgement, synchronised back to clk.
    logic run_ack_meta_reg;
    logic run_ack_reg;
    // Run request seen in the memory-core domain.
    logic run_meta_reg;
    logic run_sync_reg;
    logic run_seen_reg;
    // Refresh interval copied into the memory-core domain when stable.
    logic [IVL_W-1:0] ivl_meta_reg;
    logic [IVL_W-1:0] ivl_sync_reg;
    logic [IVL_W-1:0] ivl_prev_reg;
    logic [IVL_W-1:0] ivl_mem_reg;
    logic [IVL_W-1:0] ivl_cnt_reg;

    // Bus side outputs follow the state; debug halt changes nothing (see RULE12).
    logic drained;
    assign drained = !access_pending && !refresh_backlog;

    // Next-state logic of the power sequencer.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PS_RUN:
            begin
                if (self_refresh_request)
                begin
                    state_next = PS_DRAIN;
                end
            end
            PS_DRAIN:
            begin
                // Wait for every access and refresh to finish (see RULE1).
                if (!self_refresh_request)
                begin
                    state_next = PS_RUN;
                end
                else if (drained)
                begin
                    state_next = PS_SELF_REFRESH;
                end
            end
            PS_SELF_REFRESH:
            begin
                if (!self_refresh_request)
                begin
                    state_next = PS_RUN;
                end
                // A woken access is served before the clock may stop again (see RULE5).
                else if (mem_clock_stop_allow && dll_power_down && !access_request)
                begin
                    state_next = PS_STOPPED;
                end
            end
            PS_STOPPED:
            begin
                // A late access or cleared bits start the wake-up (see RULE5).
                if ((access_request && bus_clock_enabled) || !mem_clock_stop_allow
                    || !dll_power_down)
                begin
                    state_next = PS_RELOCK;
                end
            end
            PS_RELOCK:
            begin
                // Relock done and core clock confirmed running (see RULE24).
                if (lock_cnt_reg == 16'h0000 && run_ack_reg)
                begin
                    state_next = PS_SELF_REFRESH;
                end
            end
            default:
            begin
                state_next = PS_RUN;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= PS_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Relock counter loads on entry into the relock state and counts down.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lock_cnt_reg <= 16'h0000;
        end
        else if (state_reg == PS_STOPPED && state_next == PS_RELOCK)
        begin
            lock_cnt_reg <= 16'(LOCK_CYCLES);
        end
        else if (lock_cnt_reg != 16'h0000)
        begin
            lock_cnt_reg <= lock_cnt_reg - 16'h0001;
        end
    end

    // Loop enable drops only in the stopped state (see RULE3).
    assign dll_enable = (state_reg != PS_STOPPED);
    // Core clock keeps running unless stop is allowed and stopped (see RULE2).
    assign mem_clock_run = !(state_reg == PS_STOPPED && mem_clock_stop_allow);
    // Self-refresh command after the drain (see RULE1).
    assign enter_self_refresh = (state_reg == PS_SELF_REFRESH) || (state_reg == PS_STOPPED)
        || (state_reg == PS_RELOCK);
    // Accesses run only when awake and bus clock on (see RULE6, RULE5).
    assign access_grant = access_request && bus_clock_enabled
        && (state_reg == PS_RUN || state_reg == PS_SELF_REFRESH);
    // Ready flag low while stopped or relocking (see RULE4, RULE24).
    assign phy_ready_flag = !(state_reg == PS_STOPPED || state_reg == PS_RELOCK);

    // Run level crosses into the memory-core domain by three flip-flops.
    always_ff @(posedge mem_clk or negedge mem_rstn)
    begin
        if (!mem_rstn)
        begin
            run_meta_reg <= 1'b1;
            run_sync_reg <= 1'b1;
            run_seen_reg <= 1'b1;
        end
        else
        begin
            run_meta_reg <= mem_clock_run;
            run_sync_reg <= run_meta_reg;
            run_seen_reg <= run_sync_reg;
        end
    end

    // Running acknowledgement crosses back by two flip-flops.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            run_ack_meta_reg <= 1'b1;
            run_ack_reg <= 1'b1;
        end
        else
        begin
            run_ack_meta_reg <= run_seen_reg;
            run_ack_reg <= run_ack_meta_reg;
        end
    end

    // Bank configuration register; its unlock bit gates timing writes.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bank_cfg <= '{UNLOCK_RESET, BUSSEL_RESET, CAS_RESET, BANKSEL_RESET, PAGE_RESET};
        end
        else if (bank_cfg_we)
        begin
            bank_cfg <= bank_cfg_in;
        end
    end

    // Timing registers hold cycle counts minus one (see RULE22).
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            timing_reg_one <= TIM_RESET[TIM_W-1:0];
            timing_reg_two <= TIM_RESET[TIM_W-1:0];
        end
        else
        begin
            // Writes land only while unlocked (see RULE13).
            if (timing_one_we && bank_cfg.timing_write_unlock)
            begin
                timing_reg_one <= timing_one_in;
            end
            if (timing_two_we && bank_cfg.timing_write_unlock)
            begin
                timing_reg_two <= timing_two_in;
            end
        end
    end

    // Refresh interval register on the bus clock.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            refresh_interval_count <= INTERVAL_RESET[IVL_W-1:0];
        end
        else if (refresh_interval_we)
        begin
            refresh_interval_count <= refresh_interval_in;
        end
    end

    // Geometry decode of the bank configuration fields.
    always_comb
    begin
        // Zero selects the 32-bit dual-device bus, else 16-bit (see RULE15, RULE19).
        geometry.data_width = (bank_cfg.narrow_bus_select == BUS_32BIT) ? 6'h20 : 6'h10;
        // CAS latency field equals cycles (see RULE16).
        geometry.cas_cycles = {1'b0, bank_cfg.cas_latency_field};
        // Bank count is two to the field; three gives eight (see RULE17).
        geometry.bank_count = 4'(1 << bank_cfg.internal_bank_count);
        // Page is 256 words times two to the field; two gives 1024 (see RULE18).
        geometry.page_words = 12'(12'h100 << bank_cfg.row_page_length);
    end

    // Refresh interval is quasi-static; two flip-flops bring it into the core
    // domain and it is taken only when two synced samples agree, so a word caught
    // in mid-change is never used. It is counted in memory clock cycles (see RULE21).
    always_ff @(posedge mem_clk or negedge mem_rstn)
    begin
        if (!mem_rstn)
        begin
            ivl_meta_reg <= INTERVAL_RESET[IVL_W-1:0];
            ivl_sync_reg <= INTERVAL_RESET[IVL_W-1:0];
            ivl_prev_reg <= INTERVAL_RESET[IVL_W-1:0];
            ivl_mem_reg <= INTERVAL_RESET[IVL_W-1:0];
            ivl_cnt_reg <= INTERVAL_RESET[IVL_W-1:0];
            refresh_tick <= 1'b0;
        end
        else
        begin
            ivl_meta_reg <= refresh_interval_count;
            ivl_sync_reg <= ivl_meta_reg;
            ivl_prev_reg <= ivl_sync_reg;
            if (ivl_sync_reg == ivl_prev_reg)
            begin
                ivl_mem_reg <= ivl_prev_reg;
            end
            refresh_tick <= 1'b0;
            if (ivl_cnt_reg == '0)
            begin
                ivl_cnt_reg <= ivl_mem_reg;
                refresh_tick <= run_seen_reg;
            end
            else
            begin
                ivl_cnt_reg <= ivl_cnt_reg - 1'b1;
            end
        end
    end

endmodule

/* File: hdl/ddr2_pm_pkg.sv */
// Shared constants and carriers for the DDR2 clock-stop and bank-configuration block.
// Assumes a 10 MHz bus-side clock and a separate memory-core clock domain.
package ddr2_pm_pkg;

    // Bus-side clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 100;
    // Time the loop needs to relock after power-up, in nanoseconds.
    localparam int DLL_LOCK_NS = 1000;
    // Relock wait in bus clock cycles, rounded up.
    localparam int DLL_LOCK_CYCLES = (DLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Field widths of the bank configuration word.
    localparam int BUSSEL_W = 1;
    localparam int CAS_W = 3;
    localparam int BANKSEL_W = 3;
    localparam int PAGE_W = 3;

    // Field encodings.
    localparam logic [BUSSEL_W-1:0] BUS_32BIT = 1'h0;
    localparam logic [BUSSEL_W-1:0] BUS_16BIT = 1'h1;
    localparam logic [CAS_W-1:0] CAS_FOUR = 3'h4;
    localparam logic [BANKSEL_W-1:0] BANKS_EIGHT = 3'h3;
    localparam logic [PAGE_W-1:0] PAGE_1024 = 3'h2;

    // Reset values of the configuration fields.
    localparam logic UNLOCK_RESET = 1'h0;
    localparam logic [BUSSEL_W-1:0] BUSSEL_RESET = BUS_32BIT;
    localparam logic [CAS_W-1:0] CAS_RESET = CAS_FOUR;
    localparam logic [BANKSEL_W-1:0] BANKSEL_RESET = BANKS_EIGHT;
    localparam logic [PAGE_W-1:0] PAGE_RESET = PAGE_1024;
    localparam logic [15:0] INTERVAL_RESET = 16'h040E;
    localparam logic [31:0] TIM_RESET = 32'h0000_0000;

    // Bank configuration carrier.
    typedef struct packed {
        logic timing_write_unlock;
        logic [BUSSEL_W-1:0] narrow_bus_select;
        logic [CAS_W-1:0] cas_latency_field;
        logic [BANKSEL_W-1:0] internal_bank_count;
        logic [PAGE_W-1:0] row_page_length;
    } bank_cfg_t;

    // Decoded geometry carrier.
    typedef struct packed {
        logic [5:0] data_width;
        logic [3:0] cas_cycles;
        logic [3:0] bank_count;
        logic [11:0] page_words;
    } geom_t;

    // Power sequencing states.
    typedef enum logic [2:0] {
        PS_RUN,
        PS_DRAIN,
        PS_SELF_REFRESH,
        PS_STOPPED,
        PS_RELOCK
    } pm_state_t;

endpackage

/* File: verif/ddr2_pm_properties.sv */
// Concurrent checks on the clock-stop and bank-configuration block.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/1ns
module ddr2_pm_properties
    import ddr2_pm_pkg::*;
#(
    parameter int TIM_W = 32
)(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Control inputs.
    input wire logic mem_clock_stop_allow,
    input wire logic dll_power_down,
    input wire logic bus_clock_enabled,
    input wire logic access_request,
    input wire logic access_pending,
    input wire logic refresh_backlog,
    input wire logic timing_one_we,
    input wire logic timing_two_we,
    input wire logic [TIM_W-1:0] timing_two_in,
    // Design outputs.
    input wire logic access_grant,
    input wire logic enter_self_refresh,
    input wire logic dll_enable,
    input wire logic mem_clock_run,
    input wire logic phy_ready_flag,
    input wire bank_cfg_t bank_cfg,
    input wire geom_t geometry,
    input wire logic [TIM_W-1:0] timing_reg_one,
    input wire logic [TIM_W-1:0] timing_reg_two
);
    // Every check runs on the bus-side clock and sleeps through reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_drain_first: assert property ($rose(enter_self_refresh)
        |-> !$past(access_pending) && !$past(refresh_backlog)) else $error("early self-refresh");
    a_clock_kept: assert property (!mem_clock_run |-> mem_clock_stop_allow)
        else $error("core clock stopped without leave");
    a_loop_down: assert property ($fell(dll_enable)
        |-> $past(dll_power_down) && $past(mem_clock_stop_allow)) else $error("loop off early");
    a_ready_low: assert property (!mem_clock_run |-> !phy_ready_flag && !dll_enable)
        else $error("ready flag high while stopped");
    a_late_wake: assert property (!dll_enable && access_request && bus_clock_enabled
        |=> dll_enable ##[1:60] phy_ready_flag) else $error("late access did not wake");
    a_ready_back: assert property ($rose(phy_ready_flag)
        |-> dll_enable && mem_clock_run) else $error("ready before relock");
    a_gated_idle: assert property (access_grant
        |-> bus_clock_enabled && access_request) else $error("grant with bus clock off");
    a_lock_holds: assert property (timing_one_we && !bank_cfg.timing_write_unlock
        |=> $stable(timing_reg_one)) else $error("locked timing write taken");
    a_unlock_takes: assert property (timing_two_we && bank_cfg.timing_write_unlock
        |=> timing_reg_two == $past(timing_two_in)) else $error("unlocked timing write lost");
    a_width_map: assert property (bank_cfg.narrow_bus_select == BUS_32BIT
        |-> geometry.data_width == 6'h20) else $error("bus width decode");
    a_cas_map: assert property (bank_cfg.cas_latency_field == CAS_FOUR
        |-> geometry.cas_cycles == 4'h4) else $error("cas decode");
    a_bank_map: assert property (bank_cfg.internal_bank_count == BANKS_EIGHT
        |-> geometry.bank_count == 4'h8) else $error("bank decode");
    a_page_map: assert property (bank_cfg.row_page_length == PAGE_1024
        |-> geometry.page_words == 12'h400) else $error("page decode");

    // Main scenarios: full stop, relock and a granted access.
    c_stopped: cover property (!mem_clock_run);
    c_relock: cover property ($rose(dll_enable));
    c_grant: cover property (access_grant);
endmodule

bind ddr2_clock_stop_and_bank_config ddr2_pm_properties #(.TIM_W(TIM_W)) u_props (
    .clk, .rstn, .mem_clock_stop_allow, .dll_power_down, .bus_clock_enabled,
    .access_request, .access_pending, .refresh_backlog, .timing_one_we, .timing_two_we,
    .timing_two_in, .access_grant, .enter_self_refresh, .dll_enable, .mem_clock_run,
    .phy_ready_flag, .bank_cfg, .geometry, .timing_reg_one, .timing_reg_two
);

/* File: verif/ddr2_mem_model.sv */
// Memory-side model: the core clock source and the attached device.
// Assumes the controller asks for its clock through mem_clock_run.
`timescale 1ns/1ns
module ddr2_mem_model (
    // Requests from the controller.
    input wire logic mem_clock_run,
    input wire logic enter_self_refresh,
    // Clock back to the controller and a fault flag.
    output logic mem_clk,
    output logic gate_fault
);
    // The 125 ns clock stands still while the controller lets it stop.
    initial
    begin
        mem_clk = 1'b0;
        #37;
        forever
        begin
            #62;
            if (mem_clock_run) mem_clk = ~mem_clk;
            #63;
            if (mem_clock_run) mem_clk = ~mem_clk;
        end
    end

    // A clock taken away from a device not in self-refresh would lose data.
    initial gate_fault = 1'b0;
    always @(negedge mem_clock_run)
        if (!enter_self_refresh) gate_fault = 1'b1;
endmodule

/* File: verif/tb_ddr2_clock_stop_and_bank_config.sv */
// Self-checking bench for the clock-stop and bank-configuration block.
// Assumes the memory-side model supplies the core clock.
`timescale 1ns/1ns
module tb_ddr2_clock_stop_and_bank_config;
    import ddr2_pm_pkg::*;
    // One configuration case and the geometry it should decode to.
    typedef struct packed {
        bank_cfg_t cfg;
        geom_t geo;
    } row_t;
    logic clk, rstn, self_refresh_request, mem_clock_stop_allow, dll_power_down;
    logic bus_clock_enabled, debug_halt, bank_cfg_we, refresh_interval_we;
    logic timing_one_we, timing_two_we, access_request, access_pending, refresh_backlog;
    logic access_grant, enter_self_refresh, dll_enable, mem_clock_run, phy_ready_flag;
    logic mem_clk, refresh_tick, gate_fault;
    bank_cfg_t bank_cfg_in, bank_cfg;
    geom_t geometry;
    logic [15:0] refresh_interval_in, refresh_interval_count;
    logic [31:0] timing_one_in, timing_two_in, timing_reg_one, timing_reg_two;
    int error_cnt, total_checks;
    row_t rows [3];

    ddr2_clock_stop_and_bank_config u_dut (
        .clk, .rstn, .mem_clk, .mem_rstn(rstn), .self_refresh_request, .mem_clock_stop_allow,
        .dll_power_down, .bus_clock_enabled, .debug_halt, .bank_cfg_in, .bank_cfg_we,
        .refresh_interval_in, .refresh_interval_we, .timing_one_in, .timing_one_we,
        .timing_two_in, .timing_two_we, .access_request, .access_pending, .refresh_backlog,
        .access_grant, .enter_self_refresh, .dll_enable, .mem_clock_run, .phy_ready_flag,
        .bank_cfg, .geometry, .refresh_interval_count, .timing_reg_one, .timing_reg_two,
        .refresh_tick
    );
    ddr2_mem_model u_mem (.mem_clock_run, .enter_self_refresh, .mem_clk, .gate_fault);

    // Bus-side clock at 100 ns.
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts one comparison and reports a mismatch.
    task automatic check_val(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Waits, bounded, for the ready flag to reach a level.
    task automatic wait_ready(input logic lvl);
        int n;
        n = 0;
        while (phy_ready_flag !== lvl && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        check_val(32'(lvl), 32'(phy_ready_flag));
    endtask

    // One-cycle write of the bank configuration.
    task automatic wr_cfg(input bank_cfg_t c);
        @(posedge clk);
        bank_cfg_in <= c;
        bank_cfg_we <= 1'h1;
        @(posedge clk);
        bank_cfg_we <= 1'h0;
        @(negedge clk);
    endtask

    // One-cycle write of both timing words and the refresh interval.
    task automatic wr_tim(input logic [31:0] v);
        @(posedge clk);
        {timing_one_in, timing_two_in, refresh_interval_in} <= {v, ~v, v[15:0]};
        {timing_one_we, timing_two_we, refresh_interval_we} <= 3'h7;
        @(posedge clk);
        {timing_one_we, timing_two_we, refresh_interval_we} <= 3'h0;
        @(negedge clk);
    endtask

    // Watchdog sized well above the hundred or so cycles the run needs.
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("unexpected at %0t: run did not finish", $time);
        complete_run();
    end

    // Main sequence: reset, configuration rows, then the power cases.
    initial
    begin
        error_cnt = 0;
        total_checks = 0;
        {rstn, self_refresh_request, mem_clock_stop_allow, dll_power_down} = 4'h0;
        {debug_halt, bank_cfg_we, refresh_interval_we, timing_one_we, timing_two_we} = 5'h0;
        {access_request, access_pending, refresh_backlog} = 3'h0;
        bus_clock_enabled = 1'h1;
        bank_cfg_in = '0;
        {refresh_interval_in, timing_one_in, timing_two_in} = '0;
        rows[0] = {1'h1, BUS_32BIT, CAS_FOUR, BANKS_EIGHT, PAGE_1024, 6'h20, 4'h4, 4'h8, 12'h400};
        rows[1] = {1'h0, BUS_16BIT, 3'h3, 3'h2, 3'h1, 6'h10, 4'h3, 4'h4, 12'h200};
        rows[2] = {1'h0, BUS_32BIT, 3'h5, 3'h0, 3'h0, 6'h20, 4'h5, 4'h1, 12'h100};
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        check_val(32'h11A, 32'(bank_cfg));
        check_val(32'h40E, 32'(refresh_interval_count));
        check_val(32'h1, 32'(phy_ready_flag));
        wr_tim(32'h1234_5678);
        check_val(32'h0, timing_reg_one);
        check_val(32'h5678, 32'(refresh_interval_count));
        foreach (rows[i])
        begin
            wr_cfg(rows[i].cfg);
            check_val(32'(rows[i].geo), 32'(geometry));
        end
        wr_cfg(rows[0].cfg);
        check_val(32'h4, 32'(geometry.cas_cycles));
        wr_tim(32'hCAFE_0001);
        check_val(32'hCAFE_0001, timing_reg_one);
        check_val(32'h3501_FFFE, timing_reg_two);
        wr_cfg(rows[2].cfg);
        wr_tim(32'h0BAD_0002);
        check_val(32'hCAFE_0001, timing_reg_one);
        // A debug halt must not stop a granted access; a gated bus clock must.
        @(posedge clk);
        {debug_halt, access_request} <= 2'h3;
        @(negedge clk);
        check_val(32'h1, 32'(access_grant));
        @(posedge clk);
        bus_clock_enabled <= 1'h0;
        @(negedge clk);
        check_val(32'h0, 32'(access_grant));
        @(posedge clk);
        {bus_clock_enabled, debug_halt, access_request, access_pending} <= 4'h9;
        self_refresh_request <= 1'h1;
        repeat (4) @(negedge clk);
        check_val(32'h0, 32'(enter_self_refresh));
        @(posedge clk);
        access_pending <= 1'h0;
        repeat (3) @(negedge clk);
        check_val(32'h1, 32'(enter_self_refresh));
        @(posedge clk);
        mem_clock_stop_allow <= 1'h1;
        repeat (3) @(negedge clk);
        check_val(32'h3, 32'({dll_enable, mem_clock_run}));
        @(posedge clk);
        dll_power_down <= 1'h1;
        wait_ready(1'h0);
        check_val(32'h0, 32'({dll_enable, mem_clock_run}));
        @(posedge clk);
        access_request <= 1'h1;
        wait_ready(1'h1);
        check_val(32'h7, 32'({access_grant, dll_enable, mem_clock_run}));
        @(posedge clk);
        access_request <= 1'h0;
        wait_ready(1'h0);
        @(posedge clk);
        {bus_clock_enabled, access_request} <= 2'h1;
        repeat (20) @(negedge clk);
        check_val(32'h0, 32'({access_grant, phy_ready_flag, dll_enable}));
        @(posedge clk);
        {bus_clock_enabled, access_request} <= 2'h2;
        @(posedge clk);
        mem_clock_stop_allow <= 1'h0;
        @(posedge clk);
        dll_power_down <= 1'h0;
        wait_ready(1'h1);
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        repeat (3) @(posedge clk);
        self_refresh_request <= 1'h0;
        repeat (3) @(posedge clk);
        access_request <= 1'h1;
        repeat (2) @(negedge clk);
        check_val(32'h3, 32'({access_grant, phy_ready_flag}));
        check_val(32'h0, 32'(gate_fault));
        complete_run();
    end
endmodule
